// *** core/acs_control_status.sv ***
// acs_control_status: control word, conversion/calibration, status word
// What this block does
// - range bit 0: unipolar, straight binary
// - range bit 1: bipolar, twos complement
// - writing trigger 1 starts one conversion
// - trigger bit self-clears when conversion completes
// - trigger also usable inside system calibration
// - kind bit: 0 self, 1 system calibration
// - launch starts chosen calibration, self-clears
// - launch 0: select bits address coefficients
// - self, code 00: array, gain, offset
// - self 01/10/11: gain+offset, offset, gain
// - system, code 00: array, gain, offset
// - system 01/10/11: gain+offset, offset, gain
// - read source 11 returns status word
// - status 15..10 zero, 7..6 one
// - status 9..8 show power setting
// - status 5 shows input range
// - status 4 busy: conversion or calibration
// - status 3 shows calibration kind
// - status 0 one while calibrating
// - status 2..1 show select bits
// - target 11 loads 14 low bits
// - source 11 holds until changed
`timescale 1ns/1ps
module acs_control_status
    import acs_pkg::*;
#(
    parameter int CONV_COUNT = CONV_CYCLES, // conversion length, cycles
    parameter int STEP_COUNT = STEP_CYCLES // calibration step, cycles
) (
    input wire logic clk, // master clock
    input wire logic rst_n, // sync reset, active low
    input wire logic wr_strobe, // one-cycle host write
    input wire logic [1:0] write_target, // {hi, lo} target lines
    input wire logic [15:0] wr_data, // host write data
    input wire logic rd_strobe, // one-cycle host read
    input wire logic [11:0] conv_result_raw, // analog result, offset bin
    input wire logic [15:0] test_data, // test register contents
    input wire logic [15:0] cal_coef_data, // addressed coefficient
    output logic [15:0] rd_data, // data of last read
    output logic [1:0] read_source, // active read source
    output logic [1:0] cal_coef_addr, // coefficient address
    output logic cal_coef_access, // coefficient path usable
    output logic [1:0] power_down_ctl, // power management setting
    output logic bipolar_range, // analog range select
    output logic conv_active, // conversion running
    output logic cal_active, // calibration running
    output acs_step_e cal_step, // current calibration step
    output logic cal_step_system, // step uses system input
    output logic [15:0] status_word, // live status word
    output logic [11:0] conv_result, // coded last result
    output logic conv_done // one-cycle end of conversion
);
    // register state of the top level
    typedef struct packed {
        logic [13:0] ctl; // control word
        logic conv_run; // conversion in progress
        logic cal_run; // calibration in progress
        logic busy; // registered busy flag
        logic [15:0] rd; // read data holding register
        logic [11:0] result; // coded result
        logic done; // conversion end pulse
    } acs_top_s;

    acs_top_s q;
    acs_top_s next_q;

    logic ctl_write; // control write this cycle
    logic trig_set; // trigger written as one
    logic launch_set; // launch written as one
    logic conv_start; // start a conversion timer
    logic cal_start; // start a calibration sequence
    logic conv_timer_done; // conversion timer ended
    logic step_start; // calibration step begins
    logic step_done; // calibration step ended
    logic cal_finish; // calibration end pulse
    logic seq_active; // sequencer running
    logic [11:0] coded; // result after range coding
    logic [15:0] stat; // assembled status word

    // decode: only target 11 reaches the control word
    assign ctl_write = wr_strobe && (write_target == TARGET_CONTROL);
    assign trig_set = ctl_write && wr_data[BIT_TRIG];
    assign launch_set = ctl_write && wr_data[BIT_LAUNCH];
    // a trigger during a running conversion is not a second start
    assign conv_start = trig_set && !q.conv_run;
    // the sequencer only sees launches that the flag accepts, so it
    // cannot restart between its end pulse and the flag clearing
    assign cal_start = launch_set && !q.cal_run;

    // conversion timer
    acs_timer #(
        .COUNT(CONV_COUNT)
    ) u_conv_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(conv_start),
        .done(conv_timer_done)
    );

    // calibration step timer, shared by every step of a sequence
    acs_timer #(
        .COUNT(STEP_COUNT)
    ) u_step_timer (
        .clk(clk),
        .rst_n(rst_n),
        .start(step_start),
        .done(step_done)
    );

    // calibration sequencer
    acs_cal_seq u_cal_seq (
        .clk(clk),
        .rst_n(rst_n),
        .launch(cal_start),
        .kind(wr_data[BIT_KIND]),
        .sel(wr_data[BIT_SEL_HI:BIT_SEL_LO]),
        .step_done(step_done),
        .step_start(step_start),
        .step(cal_step),
        .step_system(cal_step_system),
        .active(seq_active),
        .finish(cal_finish)
    );

    // range coding: flip the msb for twos complement
    always_comb begin
        coded = conv_result_raw;
        if (q.ctl[BIT_RANGE]) begin
            coded = {~conv_result_raw[11], conv_result_raw[10:0]};
        end
    end

    // status word assembly from live control and busy state
    always_comb begin
        stat = 16'h0000; // 15..10 stay zero
        stat[BIT_PD_HI:BIT_PD_LO] = q.ctl[BIT_PD_HI:BIT_PD_LO];
        stat[BIT_RD_HI:BIT_RD_LO] = 2'h3; // fixed ones
        stat[BIT_RANGE] = q.ctl[BIT_RANGE];
        stat[BIT_BUSY] = q.busy;
        stat[BIT_KIND] = q.ctl[BIT_KIND];
        stat[BIT_SEL_HI:BIT_SEL_LO] = q.ctl[BIT_SEL_HI:BIT_SEL_LO];
        stat[BIT_LAUNCH] = q.ctl[BIT_LAUNCH];
    end

    // next state of the control word and flags
    always_comb begin
        next_q = q;
        next_q.done = 1'b0;
        if (ctl_write) begin
            // low 14 bits load; 13..10 kept as written, host keeps zero
            next_q.ctl = wr_data[CTL_WIDTH-1:0];
            // a running job keeps its own bit set until it ends
            if (q.conv_run) begin
                next_q.ctl[BIT_TRIG] = 1'b1;
            end
            if (q.cal_run) begin
                next_q.ctl[BIT_LAUNCH] = 1'b1;
            end
        end
        if (conv_start) begin
            next_q.conv_run = 1'b1;
        end
        if (conv_timer_done) begin
            next_q.conv_run = 1'b0;
            next_q.ctl[BIT_TRIG] = 1'b0; // self-clear
            next_q.result = coded;
            next_q.done = 1'b1;
        end
        if (cal_start) begin
            next_q.cal_run = 1'b1;
        end
        if (cal_finish) begin
            next_q.cal_run = 1'b0;
            next_q.ctl[BIT_LAUNCH] = 1'b0; // self-clear
        end
        // busy follows either job, on the master clock
        next_q.busy = next_q.conv_run || next_q.cal_run;
        if (rd_strobe) begin
            // source stays until the next control write
            unique case (q.ctl[BIT_RD_HI:BIT_RD_LO])
                SOURCE_DATA: next_q.rd = {4'h0, q.result};
                SOURCE_TEST: next_q.rd = test_data;
                SOURCE_CAL: next_q.rd = {2'h0, cal_coef_data[13:0]};
                SOURCE_STATUS: next_q.rd = stat;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
            q.ctl <= CTL_RESET;
        end else begin
            q <= next_q;
        end
    end

    // outputs
    assign rd_data = q.rd;
    assign read_source = q.ctl[BIT_RD_HI:BIT_RD_LO];
    assign cal_coef_addr = q.ctl[BIT_SEL_HI:BIT_SEL_LO];
    // coefficient address is meaningful only with launch clear
    assign cal_coef_access = !q.ctl[BIT_LAUNCH] && !seq_active;
    assign power_down_ctl = q.ctl[BIT_PD_HI:BIT_PD_LO];
    assign bipolar_range = q.ctl[BIT_RANGE];
    // a system calibration may use the trigger as well
    assign conv_active = q.conv_run;
    assign cal_active = q.cal_run;
    assign status_word = stat;
    assign conv_result = q.result;
    assign conv_done = q.done;
endmodule : acs_control_status

// *** core/acs_pkg.sv ***
// acs_pkg: shared constants and types for the converter control logic
package acs_pkg;
    // control word field positions
    localparam int CTL_WIDTH = 14;
    localparam int STAT_WIDTH = 16;
    localparam int BIT_LAUNCH = 0;
    localparam int BIT_SEL_LO = 1;
    localparam int BIT_SEL_HI = 2;
    localparam int BIT_KIND = 3;
    localparam int BIT_TRIG = 4;
    localparam int BIT_RANGE = 5;
    localparam int BIT_RD_LO = 6;
    localparam int BIT_RD_HI = 7;
    localparam int BIT_PD_LO = 8;
    localparam int BIT_PD_HI = 9;
    localparam int BIT_BUSY = 4;
    // reset value of the control word
    localparam logic [13:0] CTL_RESET = 14'h0000;
    // write target and read source codes
    localparam logic [1:0] TARGET_CONTROL = 2'h3;
    localparam logic [1:0] SOURCE_DATA = 2'h0;
    localparam logic [1:0] SOURCE_TEST = 2'h1;
    localparam logic [1:0] SOURCE_CAL = 2'h2;
    localparam logic [1:0] SOURCE_STATUS = 2'h3;
    // timing, in ns, and derived cycle counts at 125 MHz
    localparam int CLK_PERIOD_NS = 8;
    localparam int CONV_TIME_NS = 4000;
    localparam int STEP_TIME_NS = 16000;
    localparam int CONV_CYCLES =
        (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_CYCLES =
        (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // calibration steps
    typedef enum logic [2:0] {
        ACS_STEP_NONE,
        ACS_STEP_ARRAY,
        ACS_STEP_GAIN,
        ACS_STEP_OFFSET
    } acs_step_e;
endpackage : acs_pkg

// *** core/acs_timer.sv ***
// acs_timer: one-shot cycle counter reporting a done pulse
`timescale 1ns/1ps
module acs_timer
    import acs_pkg::*;
#(
    parameter int COUNT = 16 // cycles from start to done
) (
    input wire logic clk, // master clock
    input wire logic rst_n, // sync reset, active low
    input wire logic start, // begin a new count
    output logic done // one-cycle pulse at the end
);
    localparam int CW = $clog2(COUNT + 1);
    localparam logic [CW-1:0] LAST = CW'(COUNT - 1);

    typedef struct packed {
        logic run; // counting
        logic [CW-1:0] cnt; // elapsed cycles
        logic done; // end pulse
    } acs_timer_s;

    acs_timer_s q;
    acs_timer_s next_q;

    // count up while running, pulse done on the last cycle
    always_comb begin
        next_q = q;
        next_q.done = 1'b0;
        if (start) begin
            next_q.run = 1'b1;
            next_q.cnt = '0;
        end else if (q.run) begin
            if (q.cnt == LAST) begin
                next_q.run = 1'b0;
                next_q.done = 1'b1;
            end else begin
                next_q.cnt = q.cnt + CW'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign done = q.done;
endmodule : acs_timer

// *** core/acs_cal_seq.sv ***
// acs_cal_seq: decodes calibration type and walks its steps
`timescale 1ns/1ps
module acs_cal_seq
    import acs_pkg::*;
(
    input wire logic clk, // master clock
    input wire logic rst_n, // sync reset, active low
    input wire logic launch, // one-cycle start pulse
    input wire logic kind, // 0 self, 1 system
    input wire logic [1:0] sel, // calibration select code
    input wire logic step_done, // current step finished
    output logic step_start, // begin timing a step
    output acs_step_e step, // step now running
    output logic step_system, // step uses system input
    output logic active, // calibration running
    output logic finish // one-cycle end pulse
);
    // each sequence is up to three steps, queued first to last
    typedef struct packed {
        acs_step_e cur; // running step
        acs_step_e nxt1; // queued second step
        acs_step_e nxt2; // queued third step
        logic sys; // system kind latched
        logic start; // step start pulse
        logic fin; // end pulse
    } acs_seq_s;

    acs_seq_s q;
    acs_seq_s next_q;

    // load a sequence on launch, then advance on each step end
    always_comb begin
        next_q = q;
        next_q.start = 1'b0;
        next_q.fin = 1'b0;
        if (launch && q.cur == ACS_STEP_NONE) begin
            next_q.sys = kind;
            next_q.start = 1'b1;
            // kind only changes the gain/offset source
            unique case (sel)
                2'h0: begin // array, gain, offset
                    next_q.cur = ACS_STEP_ARRAY;
                    next_q.nxt1 = ACS_STEP_GAIN;
                    next_q.nxt2 = ACS_STEP_OFFSET;
                end
                2'h1: begin // gain then offset
                    next_q.cur = ACS_STEP_GAIN;
                    next_q.nxt1 = ACS_STEP_OFFSET;
                    next_q.nxt2 = ACS_STEP_NONE;
                end
                2'h2: begin // offset only
                    next_q.cur = ACS_STEP_OFFSET;
                    next_q.nxt1 = ACS_STEP_NONE;
                    next_q.nxt2 = ACS_STEP_NONE;
                end
                2'h3: begin // gain only
                    next_q.cur = ACS_STEP_GAIN;
                    next_q.nxt1 = ACS_STEP_NONE;
                    next_q.nxt2 = ACS_STEP_NONE;
                end
            endcase
        end else if (q.cur != ACS_STEP_NONE && step_done) begin
            next_q.cur = q.nxt1;
            next_q.nxt1 = q.nxt2;
            next_q.nxt2 = ACS_STEP_NONE;
            if (q.nxt1 == ACS_STEP_NONE) begin
                next_q.fin = 1'b1; // last step ended
            end else begin
                next_q.start = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign step_start = q.start;
    assign step = q.cur;
    // the array step is always internal, whatever the kind
    assign step_system = q.sys && (q.cur != ACS_STEP_ARRAY);
    assign active = (q.cur != ACS_STEP_NONE);
    assign finish = q.fin;
endmodule : acs_cal_seq

// *** tb/acs_control_status_sva.sv ***
// acs_control_status_sva: port checks of the control/status logic
`timescale 1ns/1ps
module acs_control_status_sva
    import acs_pkg::*;
#(
    parameter int CONV_COUNT = 4 // conversion length, cycles
) (
    input wire logic clk, // master clock
    input wire logic rst_n, // sync reset
    input wire logic wr_strobe, // host write
    input wire logic [1:0] write_target, // target lines
    input wire logic [15:0] wr_data, // write data
    input wire logic rd_strobe, // host read
    input wire logic [15:0] rd_data, // read data
    input wire logic [1:0] read_source, // read source
    input wire logic cal_coef_access, // coefficient path
    input wire logic [1:0] power_down_ctl, // power setting
    input wire logic bipolar_range, // range select
    input wire logic conv_active, // converting
    input wire logic cal_active, // calibrating
    input wire logic [15:0] status_word, // live status
    input wire logic conv_done // end of conversion
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] cnt; // cycles spent converting
    logic [15:0] last_wd; // write data one cycle back
    logic [15:0] last_sw; // status one cycle back
    wire ctl_wr = wr_strobe && write_target == 2'h3; // control write
    // helper history; cnt clears whenever no conversion runs
    always_ff @(posedge clk) begin
        cnt <= (!rst_n || !conv_active) ? 16'h0000 : cnt + 16'h0001;
        last_wd <= wr_data;
        last_sw <= status_word;
    end
    a_status_fixed: assert property (
        status_word[15:10] == 6'h00 && status_word[7:6] == 2'h3)
        else $error("status constant bits wrong");
    a_status_fields: assert property (
        status_word[9:8] == power_down_ctl
        && status_word[5] == bipolar_range)
        else $error("status power or range bits wrong");
    a_busy_or: assert property (
        status_word[4] == (conv_active || cal_active))
        else $error("busy bit not OR of activities");
    a_cal_flag: assert property (cal_active |-> status_word[0])
        else $error("calibration flag low while calibrating");
    a_ctl_load: assert property (ctl_wr |=>
        read_source == last_wd[7:6] && power_down_ctl == last_wd[9:8]
        && bipolar_range == last_wd[5])
        else $error("control write not loaded");
    a_other_keep: assert property (
        wr_strobe && write_target != 2'h3
        |=> $stable(read_source) && $stable(bipolar_range))
        else $error("other target changed control");
    a_conv_len: assert property (
        conv_done |-> cnt == CONV_COUNT + 1 && !conv_active)
        else $error("conversion length wrong");
    a_conv_start: assert property (
        ctl_wr && wr_data[4] && !status_word[4] |=> conv_active)
        else $error("trigger did not start conversion");
    a_cal_start: assert property (
        ctl_wr && wr_data[0] && !status_word[4] |=> cal_active)
        else $error("launch did not start calibration");
    a_coef_path: assert property (
        cal_coef_access |-> !status_word[0] && !cal_active)
        else $error("coefficient path open while calibrating");
    a_rd_status: assert property (
        rd_strobe && read_source == 2'h3 |=> rd_data == last_sw)
        else $error("status read returned wrong word");
endmodule : acs_control_status_sva

bind acs_control_status acs_control_status_sva #(
    .CONV_COUNT(CONV_COUNT)
) u_sva (.clk(clk), .rst_n(rst_n), .wr_strobe(wr_strobe),
    .write_target(write_target), .wr_data(wr_data),
    .rd_strobe(rd_strobe), .rd_data(rd_data),
    .read_source(read_source), .cal_coef_access(cal_coef_access),
    .power_down_ctl(power_down_ctl), .bipolar_range(bipolar_range),
    .conv_active(conv_active), .cal_active(cal_active),
    .status_word(status_word), .conv_done(conv_done));

// *** tb/acs_host_model.sv ***
// acs_host_model: host processor on the parallel port
`timescale 1ns/1ps
module acs_host_model (
    input wire logic clk, // master clock
    output logic wr_strobe, // write pulse
    output logic [1:0] write_target, // target lines
    output logic [15:0] wr_data, // write data
    output logic rd_strobe, // read pulse
    input wire logic [15:0] rd_data // read data
);
    // idle bus at time zero
    initial begin
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        write_target = 2'h0;
        wr_data = 16'h0000;
    end
    // one write; released bus shows inverted data, not the old word
    task automatic write_word(input logic [1:0] tgt,
        input logic [15:0] d);
        @(negedge clk);
        wr_strobe = 1'b1;
        write_target = tgt;
        wr_data = d & 16'h03ff;
        @(negedge clk);
        wr_strobe = 1'b0;
        write_target = ~tgt;
        wr_data = ~wr_data;
    endtask : write_word
    // one read; data taken a cycle after the strobe edge
    task automatic read_word(output logic [15:0] d);
        @(negedge clk);
        rd_strobe = 1'b1;
        @(negedge clk);
        rd_strobe = 1'b0;
        d = rd_data;
    endtask : read_word
endmodule : acs_host_model

// *** tb/acs_control_status_tb.sv ***
// acs_control_status_tb: self-checking bench for the control logic
`timescale 1ns/1ps
module acs_control_status_tb
    import acs_pkg::*;
;
    logic clk = 1'b0; // master clock
    logic rst_n = 1'b0; // sync reset
    logic wr_strobe, rd_strobe; // host strobes
    logic [1:0] write_target; // host target
    logic [15:0] wr_data, rd_data, status_word; // port words
    logic [11:0] raw = 12'h000; // analog result
    logic [15:0] tdata = 16'h0000, cdata = 16'h0000; // side inputs
    logic [1:0] read_source, cal_coef_addr, power_down_ctl, t;
    logic cal_coef_access, bipolar_range, conv_active, cal_active;
    logic cal_step_system, conv_done; // step kind, end pulse
    logic [11:0] conv_result; // coded result
    acs_step_e cal_step, prev; // running and last step
    logic [15:0] got, d; // read word, control word
    logic [8:0] seq; // observed step order
    int miscompares = 0, checks_done = 0, seed = 90583, cyc = 0, n;
    always #4 clk = ~clk;
    acs_host_model host (.clk(clk), .wr_strobe(wr_strobe),
        .write_target(write_target), .wr_data(wr_data),
        .rd_strobe(rd_strobe), .rd_data(rd_data));
    acs_control_status #(.CONV_COUNT(4), .STEP_COUNT(4)) DUT (
        .clk(clk), .rst_n(rst_n), .wr_strobe(wr_strobe),
        .write_target(write_target), .wr_data(wr_data),
        .rd_strobe(rd_strobe), .conv_result_raw(raw),
        .test_data(tdata), .cal_coef_data(cdata), .rd_data(rd_data),
        .read_source(read_source), .cal_coef_addr(cal_coef_addr),
        .cal_coef_access(cal_coef_access),
        .power_down_ctl(power_down_ctl), .bipolar_range(bipolar_range),
        .conv_active(conv_active), .cal_active(cal_active),
        .cal_step(cal_step), .cal_step_system(cal_step_system),
        .status_word(status_word), .conv_result(conv_result),
        .conv_done(conv_done));
    // compare and count
    task automatic check(input logic [15:0] act, input logic [15:0] exp);
        checks_done++;
        if (act !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, act, exp);
        end
    endtask : check
    // status word expected from a control word
    function automatic logic [15:0] exp_stat(input logic [15:0] c,
        input logic busy, input logic cal);
        return {6'h00, c[9:8], 2'h3, c[5], busy, c[3], c[2:1], cal};
    endfunction : exp_stat
    // step order expected for a select code
    function automatic logic [8:0] exp_seq(input logic [1:0] s);
        case (s)
            2'h0: return {ACS_STEP_ARRAY, ACS_STEP_GAIN, ACS_STEP_OFFSET};
            2'h1: return {ACS_STEP_NONE, ACS_STEP_GAIN, ACS_STEP_OFFSET};
            2'h2: return {6'h00, ACS_STEP_OFFSET};
            default: return {6'h00, ACS_STEP_GAIN};
        endcase
    endfunction : exp_seq
    // verdict and end of run
    task automatic final_report();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    // hang guard, well above the expected few hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            miscompares++;
            final_report();
        end
    end
    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        host.write_word(2'h3, 16'h00c0);
        host.read_word(got);
        check(got, 16'h00c0);
        // random fields, then a write to another target
        repeat (16) begin
            d = ($random(seed) & 16'h03ee) | 16'h00c0;
            t = $random(seed);
            host.write_word(2'h3, d);
            host.write_word((t == 2'h3) ? 2'h0 : t, ~d);
            host.read_word(got);
            check(got, exp_stat(d, 1'b0, 1'b0));
        end
        tdata = $random(seed);
        cdata = $random(seed);
        host.write_word(2'h3, 16'h0040);
        host.read_word(got);
        check(got, tdata);
        host.write_word(2'h3, 16'h0084);
        host.read_word(got);
        check(got, {2'h0, cdata[13:0]});
        check({13'h0, cal_coef_access, cal_coef_addr}, 16'h0006);
        // one conversion per range, second trigger while busy
        for (int r = 0; r < 2; r++) begin
            raw = $random(seed);
            d = 16'h00d0 | (r << 5);
            host.write_word(2'h3, d);
            host.write_word(2'h3, d);
            host.read_word(got);
            check(got, exp_stat(d, 1'b1, 1'b0));
            n = 0;
            while (conv_done !== 1'b1 && n < 50) begin
                @(negedge clk);
                n++;
            end
            check({4'h0, conv_result}, {4'h0, raw ^ {r[0], 11'h0}});
            n = 0;
            repeat (20) begin
                @(negedge clk);
                n += conv_done;
            end
            check(n[15:0], 16'h0000);
            host.read_word(got);
            check(got, exp_stat(d, 1'b0, 1'b0));
        end
        // data source: last result with four leading zeros
        host.write_word(2'h3, 16'h0000);
        host.read_word(got);
        check(got, {4'h0, raw ^ 12'h800});
        // every calibration kind and select code
        for (int k = 0; k < 8; k++) begin
            d = 16'h00c1 | (k << 1);
            host.write_word(2'h3, d);
            host.read_word(got);
            check(got, exp_stat(d, 1'b1, 1'b1));
            // trigger during a system calibration still converts
            if (k == 4) begin
                host.write_word(2'h3, d | 16'h0010);
                check(conv_active, 1'b1);
            end
            seq = 9'h000;
            prev = ACS_STEP_NONE;
            n = 0;
            while (cal_active && n < 500) begin
                if (cal_step != ACS_STEP_NONE && cal_step != prev) begin
                    seq = {seq[5:0], cal_step};
                    check(cal_step_system, k[2] && cal_step != ACS_STEP_ARRAY);
                end
                prev = cal_step;
                @(negedge clk);
                n++;
            end
            check(seq, exp_seq(k[1:0]));
            repeat (4) @(negedge clk);
            host.read_word(got);
            check(got, exp_stat(d, 1'b0, 1'b0));
        end
        final_report();
    end
endmodule : acs_control_status_tb
